// file: rtl/cssc_pkg.sv
// Package: register map, field positions and types for the clock select block
package cssc_pkg;
	// Byte offsets, chosen, one aligned word each
	localparam logic [7:0] OFF_MODE_A = 8'h00;
	localparam logic [7:0] OFF_MODE_B = 8'h04;
	localparam logic [7:0] OFF_DETECT = 8'h08;
	localparam logic [7:0] OFF_FAST_CTL = 8'h0C;
	localparam logic [7:0] OFF_FAST_DIV = 8'h10;
	localparam logic [7:0] OFF_PROTECT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// Field positions
	localparam int B_MAIN_STOP = 5;
	localparam int B_DIV_SEL = 6;
	localparam int B_STOP_MODE = 0;
	localparam int B_PIN_FUNC = 3;
	localparam int B_SLOW_STOP = 4;
	localparam int B_DRIVE = 5;
	localparam int B_FINE_LO = 6;
	localparam int B_DET_EN = 0;
	localparam int B_DET_IRQ = 1;
	localparam int B_SYS_SEL = 2;
	localparam int B_MAIN_STOPPED = 3;
	localparam int B_FAST_EN = 0;
	localparam int B_SRC_SEL = 1;
	localparam int B_WREN = 0;
	// Reset values
	localparam logic [7:0] RST_MODE_A = 8'h68;
	localparam logic [7:0] RST_MODE_B = 8'h20;
	localparam logic [7:0] RST_DETECT = 8'h04;
	localparam logic [7:0] RST_FAST_CTL = 8'h00;
	localparam logic [2:0] RST_FAST_DIV = 3'h0;
	// Field codes
	localparam logic [1:0] DET_FALLBACK = 2'h3;
	localparam logic [1:0] DET_OFF = 2'h0;
	localparam logic [2:0] DIV_BY8 = 3'h3;
	// Stop-detect timeout on the system clock, and the filter depth
	localparam int STOP_TIMEOUT = 64;
	localparam int SYNC_DEPTH = 3;

	// Clock source steering handed to the analogue side
	typedef struct packed {
		logic main_osc_on;
		logic main_feedback_on;
		logic main_drive_high;
		logic slow_osc_on;
		logic fast_osc_on;
		logic onchip_source_select;
		logic system_clock_select;
		logic [2:0] cpu_div_code;
	} cssc_ctl_t;
endpackage

// file: rtl/cssc_stop_det.sv
// Module: main oscillator stop detector by edge timeout
`timescale 1ns/1ps
module cssc_stop_det #(
	parameter int TIMEOUT = cssc_pkg::STOP_TIMEOUT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic osc_sync,
	output logic stopped
);
	localparam int CW = $clog2(TIMEOUT + 1);
	localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);
	logic prev_r;
	logic [CW-1:0] cnt_r;
	wire edge_seen = osc_sync ^ prev_r;
	// Counter restarts on every oscillator edge; saturating at limit = stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
			cnt_r <= '0;
			stopped <= 1'b0;
		end else begin
			prev_r <= osc_sync;
			if (!enable || edge_seen)
				cnt_r <= '0;
			else if (cnt_r != LIMIT)
				cnt_r <= cnt_r + CW'(1);
			stopped <= enable && (cnt_r == LIMIT);
		end
	end
endmodule

// file: rtl/cssc_sync.sv
// Module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cssc_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	// First stage feeds only the second; change counts when two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				dout <= s3_r;
		end
	end
endmodule

// file: rtl/cssc_top.sv
// Module: clock source select control with APB register access
// Contract
// [RL1] Clock registers ignore writes unless clock_write_enable is 1.
// [RL2] Stop mode entry forces divide_select to 1 (divide by 8).
// [RL3] Stop mode entry forces drive_capacity high.
// [RL4] Fine divide field only applies while divide_select is 0.
// [RL5] Stop mode bit disconnects the main feedback resistor.
// [RL6] slow_osc_stop follows system clock select; writes of 1 ignored on chip.
// [RL7] Stop mode with pin function 1 drives out pin high, else input.
// [RL8] Watchdog protect mode ignores writes to stop mode and slow stop.
// [RL9] osc_pin_function cannot be cleared once set.
// [RL10] Detected main stop with field 11b sets system_clock_select.
// [RL11] While main_stopped_status is 1, writing 0 to select is ignored.
// [RL12] Stopped status valid with detect enable; held 0 when field 00b.
// [RL13] Software clears detect field before stop or fast source use.
// [RL14] Software clears field, selects on-chip, then stops main osc.
// [RL15] Main stop with external clock only turns off the buffer.
// [RL16] Oscillator pins become inputs when main stopped and pin func 0.
// [RL17] Software changes source select only with fast on, slow running.
// [RL18] Software clears fast enable only after source select returns slow.
// [RL19] Software keeps slow oscillator on when filtered voltage detect used.
// [RL20] Main oscillates only when main stop cleared after pin func set.
// [RL21] Reset selects slow on-chip oscillator by 8, main and fast off.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module cssc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic stop_mode_entry,
	input wire logic wdt_protect_mode,
	input wire logic main_osc_in_pin,
	output logic main_osc_out_pin,
	output logic main_osc_out_oe,
	output logic buffer_on,
	output logic port_pins_free,
	output cssc_pkg::cssc_ctl_t ctl
);
	logic [7:0] mode_a_r;
	logic [7:0] mode_b_r;
	logic [7:0] detect_r;
	logic [7:0] fast_ctl_r;
	logic [2:0] fast_div_r;
	logic wren_r;
	logic pin_in;
	logic main_stop_seen;
	logic stop_prev_r;

	// Address match; one helper keeps every select decoded the same way
	function automatic logic hit_off(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	// Register decode, one access phase per transfer, always zero wait
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire hit_a = hit_off(paddr, cssc_pkg::OFF_MODE_A);
	wire hit_b = hit_off(paddr, cssc_pkg::OFF_MODE_B);
	wire hit_d = hit_off(paddr, cssc_pkg::OFF_DETECT);
	wire hit_f = hit_off(paddr, cssc_pkg::OFF_FAST_CTL);
	wire hit_v = hit_off(paddr, cssc_pkg::OFF_FAST_DIV);
	wire hit_p = hit_off(paddr, cssc_pkg::OFF_PROTECT);
	wire hit_s = hit_off(paddr, cssc_pkg::OFF_STATUS);
	wire mapped = hit_a | hit_b | hit_d | hit_f | hit_v | hit_p | hit_s;
	// Clock registers only accept writes behind the protect bit
	wire wr_ok = wr && wren_r; // RL1
	wire wr_a = wr_ok && hit_a;
	wire wr_b = wr_ok && hit_b;
	wire wr_d = wr_ok && hit_d;
	wire wr_f = wr_ok && hit_f;
	wire wr_v = wr_ok && hit_v;
	wire wr_p = wr && hit_p;

	// Stop mode entry is taken on its rising edge, same-clock source
	wire stop_enter = stop_mode_entry && !stop_prev_r;

	wire [1:0] det_field = {detect_r[cssc_pkg::B_DET_IRQ],
		detect_r[cssc_pkg::B_DET_EN]};
	wire det_armed = detect_r[cssc_pkg::B_DET_EN];
	wire sel_now = detect_r[cssc_pkg::B_SYS_SEL];
	wire stopped_now = detect_r[cssc_pkg::B_MAIN_STOPPED];
	// Fallback when detection runs in full mode
	wire fallback = main_stop_seen && det_field == cssc_pkg::DET_FALLBACK; // RL10

	// Next value of mode register A
	logic [7:0] mode_a_nxt;
	always_comb begin
		mode_a_nxt = mode_a_r;
		if (wr_a)
			mode_a_nxt = pwdata[7:0];
		if (stop_enter)
			mode_a_nxt[cssc_pkg::B_DIV_SEL] = 1'b1; // RL2
	end

	// Select after this edge, read by the slow stop logic below
	logic sel_nxt_w;
	// Next value of mode register B, with protect and sticky bits
	logic [7:0] mode_b_nxt;
	always_comb begin
		mode_b_nxt = mode_b_r;
		if (wr_b) begin
			mode_b_nxt = pwdata[7:0];
			if (wdt_protect_mode) begin
				mode_b_nxt[cssc_pkg::B_STOP_MODE] =
					mode_b_r[cssc_pkg::B_STOP_MODE]; // RL8
				mode_b_nxt[cssc_pkg::B_SLOW_STOP] =
					mode_b_r[cssc_pkg::B_SLOW_STOP]; // RL8
			end
			// Pin function is write-once to 1
			if (mode_b_r[cssc_pkg::B_PIN_FUNC])
				mode_b_nxt[cssc_pkg::B_PIN_FUNC] = 1'b1; // RL9
		end
		if (stop_enter)
			mode_b_nxt[cssc_pkg::B_DRIVE] = 1'b1; // RL3
		// Slow stop tracks the source select; ones ignored on-chip
		if (!sel_nxt_w)
			mode_b_nxt[cssc_pkg::B_SLOW_STOP] = 1'b1; // RL6
		else if (!sel_now || (wr_b && !wdt_protect_mode))
			mode_b_nxt[cssc_pkg::B_SLOW_STOP] = 1'b0; // RL6
	end

	// Detect register next value; fallback set beats software clear
	logic [7:0] detect_nxt;
	always_comb begin
		detect_nxt = detect_r;
		if (wr_d) begin
			detect_nxt[cssc_pkg::B_DET_EN] = pwdata[cssc_pkg::B_DET_EN];
			detect_nxt[cssc_pkg::B_DET_IRQ] = pwdata[cssc_pkg::B_DET_IRQ];
			if (pwdata[cssc_pkg::B_SYS_SEL] || !stopped_now)
				detect_nxt[cssc_pkg::B_SYS_SEL] =
					pwdata[cssc_pkg::B_SYS_SEL]; // RL11
		end
		if (fallback)
			detect_nxt[cssc_pkg::B_SYS_SEL] = 1'b1; // RL10
		// Status only meaningful while detection is armed
		if (!detect_nxt[cssc_pkg::B_DET_EN] &&
			!detect_nxt[cssc_pkg::B_DET_IRQ])
			detect_nxt[cssc_pkg::B_MAIN_STOPPED] = 1'b0; // RL12
		else if (detect_nxt[cssc_pkg::B_DET_EN])
			detect_nxt[cssc_pkg::B_MAIN_STOPPED] = main_stop_seen; // RL12
		else
			detect_nxt[cssc_pkg::B_MAIN_STOPPED] = 1'b0;
		detect_nxt[7:4] = 4'h0;
		sel_nxt_w = detect_nxt[cssc_pkg::B_SYS_SEL];
	end

	// Register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_a_r <= cssc_pkg::RST_MODE_A; // RL21
			mode_b_r <= cssc_pkg::RST_MODE_B;
			detect_r <= cssc_pkg::RST_DETECT; // RL21
			fast_ctl_r <= cssc_pkg::RST_FAST_CTL; // RL21
			fast_div_r <= cssc_pkg::RST_FAST_DIV;
			wren_r <= 1'b0;
			stop_prev_r <= 1'b0;
		end else begin
			mode_a_r <= mode_a_nxt;
			mode_b_r <= mode_b_nxt;
			detect_r <= detect_nxt;
			if (wr_f)
				fast_ctl_r <= {6'h00, pwdata[1:0]};
			if (wr_v)
				fast_div_r <= pwdata[2:0];
			if (wr_p)
				wren_r <= pwdata[cssc_pkg::B_WREN];
			stop_prev_r <= stop_mode_entry;
		end
	end

	// Read mux
	wire [7:0] rd_byte =
		hit_a ? mode_a_r :
		hit_b ? mode_b_r :
		hit_d ? detect_r :
		hit_f ? fast_ctl_r :
		hit_v ? {5'h00, fast_div_r} :
		hit_p ? {7'h00, wren_r} :
		hit_s ? {5'h00, main_stop_seen, pin_in, stop_prev_r} : 8'h00;

	// APB answer registered; unmapped addresses raise pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ?
				{24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

	// Oscillator pin into the clock domain
	cssc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(main_osc_in_pin),
		.dout(pin_in)
	);

	// Detector timed out on the filtered pin
	cssc_stop_det u_det (
		.pclk(pclk),
		.presetn(presetn),
		.enable(det_armed && !mode_a_r[cssc_pkg::B_MAIN_STOP]),
		.osc_sync(pin_in),
		.stopped(main_stop_seen)
	);

	// Derived control
	wire stop_mode = mode_b_r[cssc_pkg::B_STOP_MODE];
	wire pin_func = mode_b_r[cssc_pkg::B_PIN_FUNC];
	wire main_stop = mode_a_r[cssc_pkg::B_MAIN_STOP];
	wire [1:0] fine = mode_b_r[cssc_pkg::B_FINE_LO +: 2];
	// Divide select overrides the fine field
	wire [2:0] div_code = mode_a_r[cssc_pkg::B_DIV_SEL] ?
		cssc_pkg::DIV_BY8 : {1'b0, fine}; // RL4
	// Oscillation needs pin function set and main stop cleared
	wire main_on = pin_func && !main_stop && !stop_mode; // RL20

	// Output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			main_osc_out_pin <= 1'b0;
			main_osc_out_oe <= 1'b0;
			buffer_on <= 1'b0;
			port_pins_free <= 1'b1;
		end else begin
			ctl.main_osc_on <= main_on;
			ctl.main_feedback_on <= !stop_mode; // RL5
			ctl.main_drive_high <= mode_b_r[cssc_pkg::B_DRIVE];
			ctl.slow_osc_on <= !mode_b_r[cssc_pkg::B_SLOW_STOP];
			ctl.fast_osc_on <= fast_ctl_r[cssc_pkg::B_FAST_EN];
			ctl.onchip_source_select <= fast_ctl_r[cssc_pkg::B_SRC_SEL];
			ctl.system_clock_select <= sel_now;
			ctl.cpu_div_code <= div_code;
			// Main stop gates the buffer and main_osc_on, not the feedback; an external clock still enters
			buffer_on <= main_on; // RL15
			main_osc_out_pin <= stop_mode && pin_func; // RL7
			main_osc_out_oe <= stop_mode && pin_func; // RL7
			port_pins_free <= main_stop && !pin_func; // RL16
		end
	end

	// Rule checks on registered state, one edge behind the cause; a_status_zero and a_slow_track check the same cycle
	a_div_override: assert property (@(posedge pclk) // RL4
		disable iff (!presetn) mode_a_r[cssc_pkg::B_DIV_SEL] |=>
		ctl.cpu_div_code == cssc_pkg::DIV_BY8)
		else $error("divide select did not force by eight");
	a_stop_div: assert property (@(posedge pclk) // RL2
		disable iff (!presetn) stop_enter |=>
		mode_a_r[cssc_pkg::B_DIV_SEL] && mode_b_r[cssc_pkg::B_DRIVE])
		else $error("stop entry did not force divide and drive");
	a_protect_wr: assert property (@(posedge pclk) // RL1
		disable iff (!presetn)
		wr && hit_a && !wren_r && !stop_enter |=> $stable(mode_a_r))
		else $error("protected write changed register");
	a_fallback_sel: assert property (@(posedge pclk) // RL10
		disable iff (!presetn)
		main_stop_seen && det_field == cssc_pkg::DET_FALLBACK |=> sel_now)
		else $error("fallback did not select on-chip");
	a_sel_hold: assert property (@(posedge pclk) // RL11
		disable iff (!presetn)
		stopped_now && sel_now |=> sel_now)
		else $error("select cleared while main stopped");
	a_status_zero: assert property (@(posedge pclk) // RL12
		disable iff (!presetn)
		det_field == cssc_pkg::DET_OFF |-> !stopped_now)
		else $error("stopped status set with detection off");
	a_pin_sticky: assert property (@(posedge pclk) // RL9
		disable iff (!presetn)
		pin_func |=> pin_func)
		else $error("pin function cleared");
	a_slow_track: assert property (@(posedge pclk) // RL6
		disable iff (!presetn)
		!sel_now |-> mode_b_r[cssc_pkg::B_SLOW_STOP])
		else $error("slow oscillator on with main selected");
	a_main_osc_out_pin_high: assert property (@(posedge pclk) // RL7
		disable iff (!presetn)
		stop_mode && pin_func |=> main_osc_out_oe && main_osc_out_pin)
		else $error("out pin not driven high in stop");
	a_feedback: assert property (@(posedge pclk) // RL5
		disable iff (!presetn)
		stop_mode |=> !ctl.main_feedback_on && !buffer_on)
		else $error("feedback kept in stop mode");
	a_wdt_hold: assert property (@(posedge pclk) // RL8
		disable iff (!presetn) wdt_protect_mode && wr_b |=>
		mode_b_r[cssc_pkg::B_STOP_MODE] == $past(stop_mode))
		else $error("stop mode bit written in protect mode");

	// Drive, divide, pin, feedback, protect, select and main gate checks
	a_stop_drive: assert property (@(posedge pclk) // RL3
		disable iff (!presetn)
		stop_enter |=> mode_b_r[cssc_pkg::B_DRIVE])
		else $error("stop entry did not force high drive");
	a_fine_apply: assert property (@(posedge pclk) // RL4
		disable iff (!presetn) !mode_a_r[cssc_pkg::B_DIV_SEL] |=>
		ctl.cpu_div_code == {1'b0, $past(fine)})
		else $error("fine divide field not applied");
	a_feedback_on: assert property (@(posedge pclk) // RL5
		disable iff (!presetn)
		!stop_mode |=> ctl.main_feedback_on)
		else $error("feedback off outside stop mode");
	a_out_input: assert property (@(posedge pclk) // RL7
		disable iff (!presetn)
		!pin_func |=> !main_osc_out_oe)
		else $error("out pin driven with pin function clear");
	a_slow_wdt: assert property (@(posedge pclk) // RL8
		disable iff (!presetn)
		wdt_protect_mode && wr_b && sel_now && sel_nxt_w |=>
		$stable(mode_b_r[cssc_pkg::B_SLOW_STOP]))
		else $error("slow stop bit written in protect mode");
	a_protect_b: assert property (@(posedge pclk) // RL1
		disable iff (!presetn)
		wr && hit_b && !wren_r && !stop_enter && sel_now && sel_nxt_w
		|=> $stable(mode_b_r))
		else $error("protected write changed mode register b");
	a_protect_det: assert property (@(posedge pclk) // RL1
		disable iff (!presetn)
		wr && hit_d && !wren_r && !fallback |=> sel_now == $past(sel_now))
		else $error("protected write changed clock select");
	a_slow_on: assert property (@(posedge pclk) // RL6
		disable iff (!presetn)
		sel_nxt_w && !sel_now |=> !mode_b_r[cssc_pkg::B_SLOW_STOP])
		else $error("slow oscillator not started on select");
	a_buffer_only: assert property (@(posedge pclk) // RL15
		disable iff (!presetn)
		main_stop && !stop_mode |=> ctl.main_feedback_on && !buffer_on)
		else $error("main stop did more than gate the buffer");
	a_pins_free: assert property (@(posedge pclk) // RL16
		disable iff (!presetn)
		main_stop && !pin_func |=> port_pins_free)
		else $error("oscillator pins not freed");
	a_pins_busy: assert property (@(posedge pclk) // RL16
		disable iff (!presetn)
		pin_func |=> !port_pins_free)
		else $error("oscillator pins freed with pin function set");
	a_main_gate: assert property (@(posedge pclk) // RL20
		disable iff (!presetn)
		!pin_func || main_stop |=> !ctl.main_osc_on)
		else $error("main oscillator ran without enable order");

	// Main scenarios
	c_fallback: cover property (@(posedge pclk) disable iff (!presetn)
		fallback);
	c_stop_entry: cover property (@(posedge pclk) disable iff (!presetn)
		stop_enter);
	c_main_on: cover property (@(posedge pclk) disable iff (!presetn)
		ctl.main_osc_on);
	c_wdt_block: cover property (@(posedge pclk) disable iff (!presetn)
		wdt_protect_mode && wr_b);
	c_sel_refused: cover property (@(posedge pclk) disable iff (!presetn)
		wr_d && stopped_now && !pwdata[cssc_pkg::B_SYS_SEL]);
endmodule

// file: test/cssc_xtal_model.sv
// Crystal or external clock model feeding the main oscillator input pin
`timescale 1ns/1ps
module cssc_xtal_model (
	input wire logic run,
	input wire logic drive_on,
	output logic pin
);
	// Oscillates only while the device drives it and the bench lets it run;
	// the 7 ns half period keeps it unrelated to pclk
	initial begin
		pin = 1'b0;
		forever begin
			#7;
			if (run && drive_on) begin
				pin = ~pin;
			end
		end
	end
endmodule

// file: test/test_clock_source_select_control.sv
// Testbench for the clock source select block
`timescale 1ns/1ps
module test_clock_source_select_control;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic stop_mode_entry, wdt_protect_mode, osc_pin, xtal_run;
	logic out_pin, out_oe, buffer_on, pins_free;
	logic rerr;
	cssc_pkg::cssc_ctl_t ctl;
	int fail_count, n_checks, cyc, seed, i, mdl;
	cssc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stop_mode_entry(stop_mode_entry),
		.wdt_protect_mode(wdt_protect_mode), .main_osc_in_pin(osc_pin),
		.main_osc_out_pin(out_pin), .main_osc_out_oe(out_oe),
		.buffer_on(buffer_on), .port_pins_free(pins_free), .ctl(ctl));
	cssc_xtal_model xtal_u (.run(xtal_run), .drive_on(ctl.main_osc_on),
		.pin(osc_pin));
	// Clock and hang guard; the whole run needs a few hundred cycles
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd & m, exp);
	endtask
	initial begin
		{psel, penable, pwrite, stop_mode_entry, wdt_protect_mode} = '0;
		{paddr, pwdata, xtal_run} = '0;
		presetn = 1'b0;
		seed = 57;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset state of the mode, detect and fast control registers and of the steering outputs
		rchk(cssc_pkg::OFF_MODE_A, 32'hFFFFFFFF, 32'h68);
		rchk(cssc_pkg::OFF_MODE_B, 32'hFFFFFFFF, 32'h20);
		rchk(cssc_pkg::OFF_DETECT, 32'hFFFFFFFF, 32'h04);
		rchk(cssc_pkg::OFF_FAST_CTL, 32'hFFFFFFFF, 32'h00);
		cmp({ctl.main_osc_on, ctl.fast_osc_on, ctl.slow_osc_on}, 3'h1);
		cmp({pins_free, out_oe, buffer_on}, 3'h4);
		cmp(ctl.cpu_div_code, cssc_pkg::DIV_BY8);
		// Locked registers refuse writes; unmapped place raises an error
		apb(1'b1, cssc_pkg::OFF_MODE_A, 32'h08);
		rchk(cssc_pkg::OFF_MODE_A, 32'hFF, 32'h68);
		apb(1'b0, 8'h1C, 32'h0);
		cmp(rerr, 1'b1);
		apb(1'b1, cssc_pkg::OFF_PROTECT, 32'h1);
		// Fine field ignored while divide select is set
		apb(1'b1, cssc_pkg::OFF_MODE_B, 32'h48);
		repeat (2) @(posedge pclk);
		cmp(ctl.cpu_div_code, cssc_pkg::DIV_BY8);
		apb(1'b1, cssc_pkg::OFF_MODE_B, 32'h00);
		rchk(cssc_pkg::OFF_MODE_B, 32'h28, 32'h08);
		// Start the main oscillator, then stop mode entry event
		apb(1'b1, cssc_pkg::OFF_MODE_A, 32'h08);
		repeat (2) @(posedge pclk);
		cmp({ctl.main_osc_on, buffer_on, pins_free}, 3'h6);
		@(posedge pclk) stop_mode_entry <= 1'b1;
		@(posedge pclk) stop_mode_entry <= 1'b0;
		rchk(cssc_pkg::OFF_MODE_A, 32'h40, 32'h40);
		rchk(cssc_pkg::OFF_MODE_B, 32'h20, 32'h20);
		cmp({ctl.cpu_div_code, ctl.main_drive_high}, 4'h7);
		// Select the running main clock, then lose it with fallback armed
		xtal_run = 1'b1;
		repeat (20) @(posedge pclk);
		apb(1'b1, cssc_pkg::OFF_DETECT, 32'h03);
		rchk(cssc_pkg::OFF_MODE_B, 32'h10, 32'h10);
		repeat (20) @(posedge pclk);
		xtal_run = 1'b0;
		i = 0;
		while (ctl.system_clock_select !== 1'b1 && i < 300) begin
			@(posedge pclk);
			i++;
		end
		rchk(cssc_pkg::OFF_DETECT, 32'h0C, 32'h0C);
		apb(1'b1, cssc_pkg::OFF_DETECT, 32'h03);
		rchk(cssc_pkg::OFF_DETECT, 32'h0C, 32'h0C);
		// Software clears the detect field before any source change
		apb(1'b1, cssc_pkg::OFF_DETECT, 32'h04);
		rchk(cssc_pkg::OFF_DETECT, 32'h0C, 32'h04);
		rchk(cssc_pkg::OFF_MODE_B, 32'h10, 32'h00);
		// Field cleared and on-chip selected, so the main clock may stop
		apb(1'b1, cssc_pkg::OFF_MODE_A, 32'h68);
		repeat (2) @(posedge pclk);
		cmp({buffer_on, ctl.main_feedback_on, ctl.main_osc_on, pins_free},
			4'h4);
		// Fast oscillator first, then the on-chip source both ways
		apb(1'b1, cssc_pkg::OFF_FAST_CTL, 32'h01);
		apb(1'b1, cssc_pkg::OFF_FAST_DIV, 32'h02);
		apb(1'b1, cssc_pkg::OFF_FAST_CTL, 32'h03);
		repeat (2) @(posedge pclk);
		cmp({ctl.fast_osc_on, ctl.onchip_source_select}, 2'h3);
		apb(1'b1, cssc_pkg::OFF_FAST_CTL, 32'h01);
		apb(1'b1, cssc_pkg::OFF_FAST_CTL, 32'h00);
		repeat (2) @(posedge pclk);
		cmp({ctl.fast_osc_on, ctl.onchip_source_select}, 2'h0);
		// Watchdog protect mode locks the stop bits
		@(posedge pclk) wdt_protect_mode <= 1'b1;
		apb(1'b1, cssc_pkg::OFF_MODE_B, 32'h19);
		rchk(cssc_pkg::OFF_MODE_B, 32'h11, 32'h00);
		@(posedge pclk) wdt_protect_mode <= 1'b0;
		apb(1'b1, cssc_pkg::OFF_MODE_B, 32'h09);
		repeat (2) @(posedge pclk);
		cmp({ctl.main_feedback_on, out_pin, out_oe}, 3'h3);
		// Fast divide field with random values against the model
		for (i = 0; i < 4; i++) begin
			mdl = $random(seed);
			apb(1'b1, cssc_pkg::OFF_FAST_DIV, mdl);
			mdl = mdl & 7;
			rchk(cssc_pkg::OFF_FAST_DIV, 32'h7, mdl);
		end
		stop_test();
	end
endmodule
